// *** rtl/fsrp_defs.vh ***
// Constants for the flash status register and write-protection block.
`ifndef FSRP_DEFS_VH
`define FSRP_DEFS_VH

// ****************************************************************
// Command opcodes
// ****************************************************************
`define FSRP_OP_WREN 8'h06
`define FSRP_OP_WRDI 8'h04
`define FSRP_OP_RDSR1 8'h05
`define FSRP_OP_RDSR2 8'h35
`define FSRP_OP_RDSR3 8'h15
`define FSRP_OP_WRSR1 8'h01
`define FSRP_OP_WRSR2 8'h31
`define FSRP_OP_WRSR3 8'h11
`define FSRP_OP_VOL_WREN 8'h50
`define FSRP_OP_SUSPEND 8'h75
`define FSRP_OP_RESUME 8'h7a
`define FSRP_OP_PAGE_PROG 8'h02
`define FSRP_OP_ERASE_4K 8'h20
`define FSRP_OP_ERASE_32K 8'h52
`define FSRP_OP_ERASE_64K 8'hd8
`define FSRP_OP_CHIP_ERASE1 8'h60
`define FSRP_OP_CHIP_ERASE2 8'hc7
`define FSRP_OP_SEC_PROG 8'h42
`define FSRP_OP_SEC_ERASE 8'h44

// ****************************************************************
// Writable-bit masks and reset values
// ****************************************************************
`define FSRP_SR1_WMASK 8'hfc
`define FSRP_SR2_WMASK 8'h7b
`define FSRP_SR3_WMASK 8'h60
`define FSRP_SR1_RESET 8'h00
`define FSRP_SR2_RESET 8'h00
`define FSRP_SR3_RESET 8'h60

// ****************************************************************
// Field positions
// ****************************************************************
`define FSRP_SR1_LOCK_LO 7
`define FSRP_SR2_LOCK_HI 0
`define FSRP_SR2_QE 1
`define FSRP_SR2_CMP 6

// ****************************************************************
// Timing
// ****************************************************************
`define FSRP_CLK_PERIOD_NS 10
`define FSRP_T_WSR_NS 5000000
// Stored-write time in clock cycles, sized to the 24-bit cycle counter.
`define FSRP_WSR_CYCLES 24'd500000

// ****************************************************************
// Status write target select
// ****************************************************************
`define FSRP_SEL_SR1 2'h1
`define FSRP_SEL_SR2 2'h2
`define FSRP_SEL_SR3 2'h3

`endif

// *** rtl/fsrp_sync.v ***
// Two-flip-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module fsrp_sync #(
    parameter WIDTH = 1
) (
    input wire i_sys_clk, // System clock.
    input wire i_reset, // Asynchronous reset, active high.
    input wire i_ce, // Clock enable.
    input wire [WIDTH-1:0] i_async, // Inputs from outside the clock domain.
    output wire [WIDTH-1:0] o_sync // Synchronised inputs.
);

    // ****************************************************************
    // One two-stage chain per bit
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : gen_bit
            reg meta_q;
            reg sync_q;
            // The first stage is read only by the second stage.
            always @(posedge i_sys_clk or posedge i_reset) begin
                if (i_reset) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                end else if (i_ce) begin
                    meta_q <= i_async[g];
                    sync_q <= meta_q;
                end
            end
            assign o_sync[g] = sync_q;
        end
    endgenerate

endmodule
`default_nettype wire

// *** rtl/fsrp_status_regs.v ***
// Status registers, write latch and status-write protection of a serial flash.
`timescale 1ns/1ps
`default_nettype none
`include "fsrp_defs.vh"
module fsrp_status_regs #(
    parameter [23:0] WSR_CYCLES = `FSRP_WSR_CYCLES
) (
    input wire i_sys_clk, // System clock, 100 MHz.
    input wire i_reset, // Power-up reset, asynchronous, active high.
    input wire i_ce, // Clock enable; low freezes all state.
    input wire i_spi_sclk, // Serial clock pin.
    input wire i_spi_cs_n, // Chip select pin, active low.
    input wire i_spi_si, // Serial data in pin.
    input wire i_wp_n, // Write-protect pin, active low.
    input wire i_hold_n, // Hold pin, active low.
    input wire i_soft_reset, // Reset operation pulse from command logic.
    input wire [7:0] i_nv_sr1, // Stored first status byte.
    input wire [7:0] i_nv_sr2, // Stored second status byte.
    input wire [7:0] i_nv_sr3, // Stored third status byte.
    input wire i_array_busy, // Array program or erase running.
    input wire i_array_erase, // Running array operation is an erase.
    input wire i_array_done, // Array write completed or aborted, pulse.
    output reg o_spi_so, // Serial data out.
    output reg o_so_oe, // Output enable of serial data out.
    output reg o_array_cmd, // Accepted array write opcode, pulse.
    output reg [7:0] o_array_opcode, // Opcode for the array engine.
    output reg o_suspend_req, // Suspend request, pulse.
    output reg o_resume_req, // Resume request, pulse.
    output reg o_nv_wr, // Store a status byte, pulse.
    output reg [1:0] o_nv_wr_sel, // Which status byte to store.
    output reg [7:0] o_nv_wr_data, // Byte to store.
    output reg o_write_latch, // Write latch state.
    output reg o_busy, // Busy flag.
    output reg o_quad_io_enable, // Protect pin is a data line; the hold pin still holds.
    output reg [1:0] o_drive_strength, // Output drive strength select.
    output reg [2:0] o_sec_lock, // Security page 2..0 locks.
    output reg [5:0] o_prot_index // Protection table index {inv,gran,top,amt}.
);

    // ****************************************************************
    // Pin synchronisation and edge detection
    // ****************************************************************
    wire [4:0] pins_s;
    fsrp_sync #(.WIDTH(5)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_async({i_hold_n, i_wp_n, i_spi_si, i_spi_cs_n, i_spi_sclk}),
        .o_sync(pins_s)
    );
    wire sclk_s = pins_s[0];
    wire cs_n_s = pins_s[1];
    wire si_s = pins_s[2];
    wire wp_n_s = pins_s[3];
    wire hold_n_s = pins_s[4];

    reg sclk_prev_q;
    reg cs_prev_q;
    // Serial clock edges are seen only while selected and not held.
    wire sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s & hold_n_s;
    wire sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s & hold_n_s;
    wire cs_rise = cs_n_s & ~cs_prev_q;

    // ****************************************************************
    // State
    // ****************************************************************
    reg [4:0] bitcnt_q;
    reg [7:0] shin_q;
    reg [7:0] opcode_q;
    reg [7:0] data_q;
    reg [7:0] v1_q;
    reg [7:0] v2_q;
    reg [7:0] v3_q;
    reg wel_q;
    reg vol_pend_q;
    reg wsr_busy_q;
    reg [23:0] wsr_cnt_q;
    reg erase_paused_q;
    reg prog_paused_q;
    reg load_pend_q;
    reg rd_act_q;
    reg [1:0] rd_sel_q;
    reg [2:0] rd_bit_q;
    reg [7:0] so_shift_q;

    // ****************************************************************
    // Live status bytes
    // ****************************************************************
    wire busy = wsr_busy_q | i_array_busy;
    // Writable bits come from the working copy, the rest from hardware.
    wire [7:0] sr1 = v1_q | {6'h00, wel_q, busy};
    wire [7:0] sr2 = v2_q | {erase_paused_q, 4'h0, prog_paused_q, 2'h0};
    wire [7:0] sr3 = v3_q;
    wire lock_hi = v2_q[`FSRP_SR2_LOCK_HI];
    wire lock_lo = v1_q[`FSRP_SR1_LOCK_LO];
    // In quad mode the protect pin carries data, so it does not protect.
    wire wp_level = wp_n_s | v2_q[`FSRP_SR2_QE];
    // Lock combinations: 00 open, 01 follows pin, 10 and 11 locked.
    wire lock_open = (~lock_hi & ~lock_lo)
        | (~lock_hi & lock_lo & wp_level);

    // ****************************************************************
    // Opcode decode
    // ****************************************************************
    wire [7:0] op_now = {shin_q[6:0], si_s};
    wire op_arr = (op_now == `FSRP_OP_PAGE_PROG) || (op_now == `FSRP_OP_ERASE_4K)
        || (op_now == `FSRP_OP_ERASE_32K) || (op_now == `FSRP_OP_ERASE_64K)
        || (op_now == `FSRP_OP_CHIP_ERASE1) || (op_now == `FSRP_OP_CHIP_ERASE2)
        || (op_now == `FSRP_OP_SEC_PROG) || (op_now == `FSRP_OP_SEC_ERASE);
    wire op_rd = (op_now == `FSRP_OP_RDSR1) || (op_now == `FSRP_OP_RDSR2)
        || (op_now == `FSRP_OP_RDSR3);
    wire full_op = (bitcnt_q >= 5'd8);
    wire one_byte = (bitcnt_q == 5'd8);
    wire is_wsr = (opcode_q == `FSRP_OP_WRSR1) || (opcode_q == `FSRP_OP_WRSR2)
        || (opcode_q == `FSRP_OP_WRSR3);
    wire vol_wr = vol_pend_q & (opcode_q == `FSRP_OP_WRSR1);
    // A status write needs exactly one data byte, a free device and a lock check.
    wire wsr_ok = (bitcnt_q == 5'd16) & ~busy & lock_open
        & (wel_q | vol_wr);

    // Merge the data byte into the chosen register, writable bits only.
    reg [1:0] wsel;
    reg [7:0] wnew;
    always @* begin
        wsel = `FSRP_SEL_SR1;
        wnew = (v1_q & ~`FSRP_SR1_WMASK) | (data_q & `FSRP_SR1_WMASK);
        if (opcode_q == `FSRP_OP_WRSR2) begin
            wsel = `FSRP_SEL_SR2;
            wnew = (v2_q & ~`FSRP_SR2_WMASK) | (data_q & `FSRP_SR2_WMASK);
        end else if (opcode_q == `FSRP_OP_WRSR3) begin
            wsel = `FSRP_SEL_SR3;
            wnew = (v3_q & ~`FSRP_SR3_WMASK) | (data_q & `FSRP_SR3_WMASK);
        end
    end

    // Byte selected for the read shifter.
    wire [7:0] rd_byte = (rd_sel_q == `FSRP_SEL_SR2) ? sr2 :
        (rd_sel_q == `FSRP_SEL_SR3) ? sr3 : sr1;

    // ****************************************************************
    // Serial front end: bit counter, shifter, opcode and data capture
    // ****************************************************************
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
            bitcnt_q <= 5'h00;
            shin_q <= 8'h00;
            opcode_q <= 8'h00;
            data_q <= 8'h00;
        end else if (i_ce) begin
            sclk_prev_q <= sclk_s;
            cs_prev_q <= cs_n_s;
            if (cs_n_s) begin
                bitcnt_q <= 5'h00;
            end else if (sclk_rise) begin
                shin_q <= op_now;
                if (bitcnt_q != 5'h1f) begin
                    bitcnt_q <= bitcnt_q + 5'h01;
                end
                if (bitcnt_q == 5'd7) begin
                    opcode_q <= op_now;
                end
                if (bitcnt_q == 5'd15) begin
                    data_q <= op_now;
                end
            end
        end
    end

    // ****************************************************************
    // Status read: reload a fresh byte every eight clocks
    // ****************************************************************
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            rd_act_q <= 1'b0;
            rd_sel_q <= `FSRP_SEL_SR1;
            rd_bit_q <= 3'h0;
            so_shift_q <= 8'h00;
            o_spi_so <= 1'b0;
            o_so_oe <= 1'b0;
        end else if (i_ce) begin
            if (cs_n_s) begin
                rd_act_q <= 1'b0;
                o_so_oe <= 1'b0;
            end else if (sclk_rise && bitcnt_q == 5'd7 && op_rd) begin
                rd_act_q <= 1'b1;
                rd_bit_q <= 3'h0;
                rd_sel_q <= (op_now == `FSRP_OP_RDSR2) ? `FSRP_SEL_SR2 :
                    (op_now == `FSRP_OP_RDSR3) ? `FSRP_SEL_SR3 : `FSRP_SEL_SR1;
            end else if (sclk_fall && rd_act_q) begin
                o_so_oe <= 1'b1;
                rd_bit_q <= rd_bit_q + 3'h1;
                if (rd_bit_q == 3'h0) begin
                    o_spi_so <= rd_byte[7];
                    so_shift_q <= {rd_byte[6:0], 1'b0};
                end else begin
                    o_spi_so <= so_shift_q[7];
                    so_shift_q <= {so_shift_q[6:0], 1'b0};
                end
            end
        end
    end

    // ****************************************************************
    // Write latch, working copy, status write cycle and suspend flags
    // ****************************************************************
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            wel_q <= 1'b0;
            v1_q <= `FSRP_SR1_RESET;
            v2_q <= `FSRP_SR2_RESET;
            v3_q <= `FSRP_SR3_RESET;
            load_pend_q <= 1'b1;
            vol_pend_q <= 1'b0;
            wsr_busy_q <= 1'b0;
            wsr_cnt_q <= 24'h000000;
            erase_paused_q <= 1'b0;
            prog_paused_q <= 1'b0;
            o_array_cmd <= 1'b0;
            o_array_opcode <= 8'h00;
            o_suspend_req <= 1'b0;
            o_resume_req <= 1'b0;
            o_nv_wr <= 1'b0;
            o_nv_wr_sel <= `FSRP_SEL_SR1;
            o_nv_wr_data <= 8'h00;
        end else if (i_ce) begin
            o_array_cmd <= 1'b0;
            o_suspend_req <= 1'b0;
            o_resume_req <= 1'b0;
            o_nv_wr <= 1'b0;
            if (load_pend_q) begin
                // Copy stored bits once after release; lock-down never survives.
                load_pend_q <= 1'b0;
                v1_q <= i_nv_sr1 & `FSRP_SR1_WMASK;
                v2_q <= i_nv_sr2 & `FSRP_SR2_WMASK;
                v3_q <= i_nv_sr3 & `FSRP_SR3_WMASK;
                if (i_nv_sr2[`FSRP_SR2_LOCK_HI] && !i_nv_sr1[`FSRP_SR1_LOCK_LO]) begin
                    v1_q[`FSRP_SR1_LOCK_LO] <= 1'b0;
                    v2_q[`FSRP_SR2_LOCK_HI] <= 1'b0;
                end
            end else if (i_soft_reset) begin
                wel_q <= 1'b0;
                vol_pend_q <= 1'b0;
            end else begin
                // Array write opcode taken only with the latch set.
                if (sclk_rise && bitcnt_q == 5'd7 && op_arr && wel_q && !busy) begin
                    o_array_cmd <= 1'b1;
                    o_array_opcode <= op_now;
                end
                // Array write ended or aborted after a full opcode.
                if (i_array_done) begin
                    wel_q <= 1'b0;
                end
                // Self-timed status write cycle.
                if (wsr_busy_q) begin
                    if (wsr_cnt_q >= WSR_CYCLES - 24'h000001) begin
                        wsr_busy_q <= 1'b0;
                        wel_q <= 1'b0;
                    end else begin
                        wsr_cnt_q <= wsr_cnt_q + 24'h000001;
                    end
                end
                // Commands that act when chip select rises; short frames do nothing.
                if (cs_rise && full_op) begin
                    if (one_byte && opcode_q == `FSRP_OP_WREN && !busy) begin
                        wel_q <= 1'b1;
                    end
                    if (one_byte && opcode_q == `FSRP_OP_WRDI && !busy) begin
                        wel_q <= 1'b0;
                    end
                    if (one_byte && opcode_q == `FSRP_OP_VOL_WREN) begin
                        vol_pend_q <= 1'b1;
                    end
                    if (one_byte && opcode_q == `FSRP_OP_SUSPEND && i_array_busy) begin
                        o_suspend_req <= 1'b1;
                        erase_paused_q <= erase_paused_q | i_array_erase;
                        prog_paused_q <= prog_paused_q | ~i_array_erase;
                    end
                    if (one_byte && opcode_q == `FSRP_OP_RESUME
                        && (erase_paused_q || prog_paused_q)) begin
                        o_resume_req <= 1'b1;
                        // A paused program resumes first; a paused erase only after it.
                        prog_paused_q <= 1'b0;
                        erase_paused_q <= erase_paused_q & prog_paused_q;
                    end
                    if (is_wsr) begin
                        if (opcode_q == `FSRP_OP_WRSR1) begin
                            vol_pend_q <= 1'b0;
                        end
                        if (wsr_ok) begin
                            case (wsel)
                                `FSRP_SEL_SR2: v2_q <= wnew;
                                `FSRP_SEL_SR3: v3_q <= wnew;
                                default: v1_q <= wnew;
                            endcase
                            if (!vol_wr) begin
                                // Stored write: start the long cycle.
                                wsr_busy_q <= 1'b1;
                                wsr_cnt_q <= 24'h000000;
                                o_nv_wr <= 1'b1;
                                o_nv_wr_sel <= wsel;
                                o_nv_wr_data <= wnew;
                            end
                            // A volatile write ends here with no busy time.
                        end else if (!vol_wr) begin
                            wel_q <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Registered status outputs
    // ****************************************************************
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_write_latch <= 1'b0;
            o_busy <= 1'b0;
            o_quad_io_enable <= 1'b0;
            o_drive_strength <= 2'h3;
            o_sec_lock <= 3'h0;
            o_prot_index <= 6'h00;
        end else if (i_ce) begin
            o_write_latch <= wel_q;
            o_busy <= busy;
            o_quad_io_enable <= v2_q[`FSRP_SR2_QE];
            o_drive_strength <= v3_q[6:5];
            o_sec_lock <= v2_q[5:3];
            // Index {invert, granularity, top/bottom, amount} for the range table.
            o_prot_index <= {v2_q[`FSRP_SR2_CMP], v1_q[6:2]};
        end
    end

endmodule
`default_nettype wire

// *** bench/fsrp_checker.sv ***
// Port checker of the status register block.
`timescale 1ns/1ps
`default_nettype none
module fsrp_checker (
    input wire logic i_sys_clk, // Clock.
    input wire logic i_reset, // Reset.
    input wire logic i_spi_cs_n, // Select.
    input wire logic i_array_busy, // Array busy.
    input wire logic i_array_done, // Array done.
    input wire logic o_so_oe, // Out enable.
    input wire logic o_array_cmd, // Array command.
    input wire logic o_suspend_req, // Suspend.
    input wire logic o_nv_wr, // Store pulse.
    input wire logic o_write_latch, // Latch.
    input wire logic o_busy, // Busy.
    input wire logic [1:0] o_drive_strength // Drive.
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    // A released select must soon float the data output.
    sequence s_cs_idle;
        i_spi_cs_n [*6];
    endsequence
    // A stored write must raise busy shortly.
    sequence s_store_busy;
        ##[0:2] o_busy;
    endsequence
    a_reset_vals: assert property ($fell(i_reset) |-> o_drive_strength == 2'h3 && !o_write_latch && !o_busy) else $error("reset values wrong");
    a_busy_ends: assert property ($rose(o_busy) && !i_array_busy |-> ##[1:40] !o_busy) else $error("busy too long");
    a_done_clears: assert property (i_array_done |-> ##[1:4] !o_write_latch) else $error("latch kept");
    a_store_latch: assert property (o_nv_wr |-> o_write_latch) else $error("store without latch");
    a_store_busy: assert property (o_nv_wr |-> s_store_busy) else $error("store not busy");
    a_cmd_latch: assert property (o_array_cmd |-> o_write_latch && !o_busy) else $error("array cmd refused case");
    a_suspend_busy: assert property (o_suspend_req |-> $past(i_array_busy)) else $error("suspend while idle");
    a_oe_idle: assert property (s_cs_idle |-> !o_so_oe) else $error("output driven while idle");
endmodule
bind fsrp_status_regs fsrp_checker i_fsrp_checker (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_spi_cs_n(i_spi_cs_n), .i_array_busy(i_array_busy), .i_array_done(i_array_done),
    .o_so_oe(o_so_oe), .o_array_cmd(o_array_cmd), .o_suspend_req(o_suspend_req),
    .o_nv_wr(o_nv_wr), .o_write_latch(o_write_latch), .o_busy(o_busy),
    .o_drive_strength(o_drive_strength));
`default_nettype wire

// *** bench/fsrp_host_model.sv ***
// Serial bus host that frames flash commands.
`timescale 1ns/1ps
`default_nettype none
module fsrp_host_model (
    input wire logic i_sys_clk, // System clock.
    input wire logic i_so, // Data from the device.
    output logic o_sclk, // Serial clock.
    output logic o_cs_n, // Chip select, active low.
    output logic o_si // Data to the device.
);
    // Clock rests low and select high outside frames.
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // Waits half of a 160 ns serial period, then steps off the edge.
    task automatic half();
        repeat (8) @(posedge i_sys_clk);
        #1;
    endtask
    // Sends n bits MSB first; q keeps the last eight bits sampled.
    task automatic xfer(input logic [15:0] d, input int n, output logic [7:0] q);
        q = 8'h00;
        half();
        o_cs_n = 1'b0;
        for (int k = n - 1; k >= 0; k--) begin
            o_si = d[k];
            half();
            o_sclk = 1'b1;
            q = {q[6:0], i_so};
            half();
            o_sclk = 1'b0;
        end
        half();
        o_cs_n = 1'b1;
        o_si = ~o_si; // A released line shows no stale value.
        half();
    endtask
endmodule
`default_nettype wire

// *** bench/tb_flash_status_register_protection.sv ***
// Self-checking bench of the status register block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_flash_status_register_protection;
    logic clk = 0, rst = 1, wp_n = 1, hold_n = 1, abusy = 0, aers = 0, adone = 0, srst = 0;
    logic sclk, cs_n, si, so, soe, acmd, rres, lat, bsy, qe;
    logic [7:0] q, aop, ndat, nv2 = 8'h08;
    logic [1:0] drv, nsel;
    logic [2:0] sec;
    logic [5:0] prot;
    logic [7:0] ops [8] = '{8'h02, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h42, 8'h44};
    int error_cnt = 0, n_checks = 0, cyc = 0, ncmd = 0, nres = 0;
    always #5 clk = ~clk;
    fsrp_status_regs #(.WSR_CYCLES(24'd20)) i_fsrp_status_regs (.i_sys_clk(clk), .i_reset(rst),
        .i_ce(1'b1), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_si(si), .i_wp_n(wp_n),
        .i_hold_n(hold_n), .i_soft_reset(srst), .i_nv_sr1(8'h1f), .i_nv_sr2(nv2),
        .i_nv_sr3(8'h40), .i_array_busy(abusy), .i_array_erase(aers), .i_array_done(adone),
        .o_spi_so(so), .o_so_oe(soe), .o_array_cmd(acmd), .o_array_opcode(aop),
        .o_suspend_req(), .o_resume_req(rres), .o_nv_wr(), .o_nv_wr_sel(nsel),
        .o_nv_wr_data(ndat), .o_write_latch(lat),
        .o_busy(bsy), .o_quad_io_enable(qe), .o_drive_strength(drv), .o_sec_lock(sec),
        .o_prot_index(prot));
    // A released data line reads as the inverse of its last value.
    fsrp_host_model i_fsrp_host_model (.i_sys_clk(clk), .i_so(soe ? so : ~so), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_si(si));
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Counts accepted array commands and cuts a hung run short.
    always @(posedge clk) begin
        cyc++;
        if (acmd === 1'b1) ncmd++;
        if (rres === 1'b1) nres++;
        if (cyc == 60000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic x(input logic [15:0] d, input int n);
        i_fsrp_host_model.xfer(d, n, q);
    endtask
    task automatic rd(input logic [7:0] op, input logic [7:0] e);
        x({op, 8'h00}, 16);
        `CHK("status read", e, q)
    endtask
    // Write enable, one status write, then a read back.
    task automatic wsr(input logic [7:0] op, input logic [7:0] d, input logic [7:0] rop,
        input logic [7:0] e);
        x(16'h06, 8);
        x({op, d}, 16);
        rd(rop, e);
    endtask
    // Main sequence of scenarios.
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 0;
        repeat (8) @(posedge clk);
        `CHK("drive", 2'h2, drv)
        `CHK("sec lock", 3'h1, sec)
        `CHK("prot", 6'h07, prot)
        rd(8'h05, 8'h1c);
        rd(8'h35, 8'h08);
        x({8'h01, 8'h00}, 16);
        rd(8'h05, 8'h1c);
        hold_n = 0;
        x(16'h06, 8);
        hold_n = 1;
        `CHK("latch", 1'b0, lat)
        x(16'h06, 8);
        x(16'h00, 4);
        `CHK("latch", 1'b1, lat)
        x(16'h018, 12);
        `CHK("latch", 1'b0, lat)
        rd(8'h05, 8'h1c);
        x(16'h06, 8);
        x({8'h01, 8'h83}, 16);
        `CHK("busy", 1'b1, bsy)
        rd(8'h05, 8'h80);
        `CHK("latch", 1'b0, lat)
        `CHK("prot", 6'h00, prot)
        wp_n = 0;
        wsr(8'h01, 8'h00, 8'h05, 8'h80);
        wp_n = 1;
        wsr(8'h01, 8'h9c, 8'h05, 8'h9c);
        x(16'h50, 8);
        x({8'h01, 8'h1c}, 16);
        `CHK("busy", 1'b0, bsy)
        rd(8'h05, 8'h1c);
        `CHK("latch", 1'b0, lat)
        wsr(8'h11, 8'h20, 8'h15, 8'h20);
        `CHK("drive", 2'h1, drv)
        foreach (ops[k]) begin
            x(16'h06, 8);
            x({8'h00, ops[k]}, 8);
            adone = 1;
            @(posedge clk);
            #1 adone = 0;
            repeat (4) @(posedge clk);
            `CHK("array cmds", k + 1, ncmd)
            `CHK("latch", 1'b0, lat)
            `CHK("array op", ops[k], aop)
        end
        x(16'h02, 8);
        `CHK("array cmds", 8, ncmd)
        abusy = 1;
        for (int k = 0; k < 2; k++) begin
            aers = k[0];
            x(16'h75, 8);
            rd(8'h35, (k == 1) ? 8'h88 : 8'h0c);
            x(16'h7a, 8);
            rd(8'h35, 8'h08);
        end
        abusy = 0;
        `CHK("resumes", 2, nres)
        x(16'h06, 8);
        srst = 1;
        @(posedge clk);
        #1 srst = 0;
        repeat (3) @(posedge clk);
        `CHK("latch", 1'b0, lat)
        wsr(8'h31, 8'h2b, 8'h35, 8'h2b);
        `CHK("sec lock", 3'h5, sec)
        `CHK("quad", 1'b1, qe)
        wsr(8'h01, 8'h00, 8'h05, 8'h1c);
        `CHK("store data", 8'h2b, ndat)
        `CHK("store sel", 2'h2, nsel)
        wp_n = 0;
        nv2 = 8'h29;
        rst = 1;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        repeat (8) @(posedge clk);
        rd(8'h35, 8'h28);
        wsr(8'h01, 8'h00, 8'h05, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
